// [irq_flags_pkg.sv]
/*
  Constants for the interrupt flag register block: offsets, bit positions,
  reset values and masks. Assumes a 32-bit classic Wishbone slave port.
*/
// Operation
// - Rx done bit7, pending bit6, activity bit5
// - Bits 3..0 tx done/abort, nobuf, overflow
// - Tx bus error sets bit 14
// - Rx bus error sets bit 13
// - Clear alias +4, set alias +8
// - Invert alias +c toggles written ones
// - Unimplemented bits read zero, ignore writes
// - Rx completed event sets bit 7
// - Tx completed event sets bit 3
// - Tx abort event sets bit 2
// - Pending flag follows nonzero buffer counter
package irq_flags_pkg;
  localparam logic [7:0] flags_off = 8'h00;
  localparam logic [7:0] clr_off = 8'h04;
  localparam logic [7:0] set_off = 8'h08;
  localparam logic [7:0] inv_off = 8'h0c;
  localparam logic [7:0] enable_off = 8'h10;
  localparam logic [7:0] counter_off = 8'h14;
  localparam logic [7:0] status_off = 8'h18;
  localparam logic [7:0] smask_off = 8'h1c;

  localparam int tx_bus_error_bit = 14;
  localparam int rx_bus_error_bit = 13;
  localparam int empty_watermark_bit = 9;
  localparam int full_watermark_bit = 8;
  localparam int rx_completed_bit = 7;
  localparam int packet_waiting_bit = 6;
  localparam int rx_activity_bit = 5;
  localparam int tx_completed_bit = 3;
  localparam int tx_aborted_bit = 2;
  localparam int rx_no_buffer_bit = 1;
  localparam int rx_fifo_overflow_bit = 0;

  // Flags that software may write through the aliases
  localparam logic [31:0] writable_mask = 32'h0000_60af;
  localparam logic [31:0] flags_reset = 32'h0000_0000;
  localparam logic [7:0] counter_reset = 8'h00;
  localparam logic [7:0] counter_max = 8'hff;
  // Sticky status: bit0 flag event, bit1 counter saturated
  localparam int status_w = 2;
endpackage

// [buffer_counter.sv]
/*
  Received buffer counter: saturating up/down. Assumes strobes are
  synchronous to clk_i.
*/
`timescale 1ns/100ps
module buffer_counter #(
  parameter int width = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic inc_i,
  input wire logic dec_i,
  input wire logic clear_i,
  // State
  output logic [width-1:0] count_o,
  output logic sat_o
);
  logic [width-1:0] count_r;
  logic [width-1:0] count_nxt;
  localparam logic [width-1:0] full = '1;

  always_comb begin
    count_nxt = count_r;
    if (clear_i) begin
      count_nxt = '0;
    end else if (inc_i && !dec_i && count_r != full) begin
      count_nxt = count_r + 1'b1;
    end else if (dec_i && !inc_i && count_r != '0) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count_o = count_r;
  assign sat_o = inc_i && !dec_i && count_r == full;
endmodule

// [irq_flags.sv]
/*
  Interrupt flag register with clear/set/invert aliases, enable register,
  buffer counter and sticky status with mask. Assumes event strobes are
  single-cycle pulses synchronous to clk_i, and a classic Wishbone master.
*/
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
module irq_flags (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Event strobes
  input wire logic tx_bus_error_i,
  input wire logic rx_bus_error_i,
  input wire logic empty_watermark_i,
  input wire logic full_watermark_i,
  input wire logic rx_completed_i,
  input wire logic rx_activity_i,
  input wire logic tx_completed_i,
  input wire logic tx_aborted_i,
  input wire logic rx_no_buffer_i,
  input wire logic rx_fifo_overflow_i,
  input wire logic buffer_inc_i,
  // Interrupts
  output logic irq_o,
  output logic status_irq_o
);
  logic [31:0] flags_r, flags_nxt;
  logic [31:0] enable_r, enable_nxt;
  logic [1:0] status_r, status_nxt;
  logic [1:0] smask_r, smask_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt;
  logic irq_r, irq_nxt;
  logic sirq_r, sirq_nxt;
  logic [7:0] count;
  logic sat;
  logic [31:0] wmask, events;
  logic req, wr, rd, dec, cnt_clr;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  assign req = cyc_i && stb_i && !ack_r;
  assign wr = req && we_i;
  assign rd = req && !we_i;
  assign wmask = lane_mask(sel_i) & dat_i;
  // Counter writes: bit0 decrements, bit1 clears (stands in for restart)
  assign dec = wr && adr_i == irq_flags_pkg::counter_off && wmask[0];
  assign cnt_clr = wr && adr_i == irq_flags_pkg::counter_off && wmask[1];

  buffer_counter #(.width(8)) u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(buffer_inc_i),
    .dec_i(dec),
    .clear_i(cnt_clr),
    .count_o(count),
    .sat_o(sat)
  );

  always_comb begin
    events = '0;
    events[irq_flags_pkg::tx_bus_error_bit] = tx_bus_error_i;
    events[irq_flags_pkg::rx_bus_error_bit] = rx_bus_error_i;
    events[irq_flags_pkg::empty_watermark_bit] = empty_watermark_i;
    events[irq_flags_pkg::full_watermark_bit] = full_watermark_i;
    events[irq_flags_pkg::rx_completed_bit] = rx_completed_i;
    events[irq_flags_pkg::rx_activity_bit] = rx_activity_i;
    events[irq_flags_pkg::tx_completed_bit] = tx_completed_i;
    events[irq_flags_pkg::tx_aborted_bit] = tx_aborted_i;
    events[irq_flags_pkg::rx_no_buffer_bit] = rx_no_buffer_i;
    events[irq_flags_pkg::rx_fifo_overflow_bit] = rx_fifo_overflow_i;
  end

  // Flag register; hardware set wins over software clear
  always_comb begin
    flags_nxt = flags_r;
    if (wr) begin
      unique case (adr_i)
        irq_flags_pkg::clr_off: flags_nxt = flags_r & ~(wmask &
            irq_flags_pkg::writable_mask);
        irq_flags_pkg::set_off: flags_nxt = flags_r | (wmask &
            irq_flags_pkg::writable_mask);
        irq_flags_pkg::inv_off: flags_nxt = flags_r ^ (wmask &
            irq_flags_pkg::writable_mask);
        default: flags_nxt = flags_r;
      endcase
    end
    flags_nxt = flags_nxt | events;
    // Pending mirrors the counter; writes cannot move it
    flags_nxt[irq_flags_pkg::packet_waiting_bit] = count != 8'h00;
    flags_nxt[31:15] = '0;
    flags_nxt[12:10] = '0;
    flags_nxt[4] = 1'b0;
  end

  // Enable, sticky status and mask registers, bus answer
  always_comb begin
    enable_nxt = enable_r;
    smask_nxt = smask_r;
    status_nxt = status_r;
    dat_nxt = 32'h0000_0000;
    if (wr && adr_i == irq_flags_pkg::enable_off) begin
      enable_nxt = (enable_r & ~lane_mask(sel_i)) |
                   (wmask & irq_flags_pkg::writable_mask);
    end
    if (wr && adr_i == irq_flags_pkg::smask_off) begin
      smask_nxt = (sel_i[0]) ? dat_i[1:0] : smask_r;
    end
    if (rd) begin
      unique case (adr_i)
        irq_flags_pkg::flags_off: dat_nxt = flags_r;
        irq_flags_pkg::enable_off: dat_nxt = enable_r;
        irq_flags_pkg::counter_off: dat_nxt = {24'h00_0000, count};
        irq_flags_pkg::status_off: dat_nxt = {30'h0000_0000, status_r};
        irq_flags_pkg::smask_off: dat_nxt = {30'h0000_0000, smask_r};
        default: dat_nxt = 32'h0000_0000;
      endcase
      if (adr_i == irq_flags_pkg::status_off) begin
        status_nxt = 2'b00;
      end
    end
    // New events win over the read clear
    status_nxt[0] = status_nxt[0] | (|events);
    status_nxt[1] = status_nxt[1] | sat;
    ack_nxt = req;
    irq_nxt = |(flags_nxt & enable_nxt);
    sirq_nxt = |(status_nxt & smask_nxt);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= irq_flags_pkg::flags_reset;
      enable_r <= 32'h0000_0000;
      status_r <= 2'b00;
      smask_r <= 2'b00;
      dat_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      irq_r <= 1'b0;
      sirq_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      enable_r <= enable_nxt;
      status_r <= status_nxt;
      smask_r <= smask_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
      irq_r <= irq_nxt;
      sirq_r <= sirq_nxt;
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign irq_o = irq_r;
  assign status_irq_o = sirq_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  tx_err_set_a: assert property (tx_bus_error_i |=>
    flags_r[14]) else $error("tx bus error not flagged");
  rx_err_set_a: assert property (rx_bus_error_i |=>
    flags_r[13]) else $error("rx bus error not flagged");
  clr_alias_a: assert property (wr && adr_i == 8'h04 && wmask[7] &&
    !rx_completed_i |=> !flags_r[7]) else $error("clear alias failed");
  set_alias_a: assert property (wr && adr_i == 8'h08 && wmask[3]
    |=> flags_r[3]) else $error("set alias failed");
  inv_alias_a: assert property (wr && adr_i == 8'h0c && wmask[0] &&
    !rx_fifo_overflow_i |=> flags_r[0] != $past(flags_r[0]))
    else $error("invert alias failed");
  unimpl_zero_a: assert property (flags_r[31:15] == '0 &&
    flags_r[12:10] == '0 && !flags_r[4]) else $error("reserved bit set");
  // Invert alias may also toggle it off, so both aliases are excluded
  done_sticky_a: assert property (flags_r[7] && !(wr &&
    (adr_i == 8'h04 || adr_i == 8'h0c)) |=> flags_r[7])
    else $error("rx done lost");
  tx_done_a: assert property (tx_completed_i |=> flags_r[3])
    else $error("tx done not flagged");
  tx_abort_a: assert property (tx_aborted_i |=> flags_r[2])
    else $error("tx abort not flagged");
  pending_a: assert property (##1 flags_r[6] ==
    ($past(count) != 8'h00)) else $error("pending flag wrong");
  irq_out_a: assert property (irq_o ==
    |(flags_r & enable_r)) else $error("irq output wrong");
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");

  irq_cov: cover property (!irq_o ##1 irq_o);
  clr_cov: cover property (wr && adr_i == 8'h04);
  inv_cov: cover property (wr && adr_i == 8'h0c);
  sat_cov: cover property (status_r[1]);
endmodule

// [wb_master.sv]
/*
  Classic Wishbone master standing in for processor software.
  Assumes a slave that answers with a one-cycle ack.
*/
`timescale 1ns/100ps
module wb_master (
  // Bus
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // Bounded wait: to flags a slave that never answers
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic to);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    q = dat_i;
    to = (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data must not look like the last value
    dat_o <= ~d;
  endtask
endmodule

// [irq_flags_tb_top.sv]
/*
  Self-checking bench for the interrupt flag register block.
  Assumes wb_master as the software side.
*/
`timescale 1ns/100ps
module irq_flags_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, irq, sirq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [10:0] ev = 11'h000;
  int errors = 0;
  int cmp_count = 0;
  localparam int pos[10] = '{14, 13, 9, 8, 7, 5, 3, 2, 1, 0};

  always #2.5 clk_i = ~clk_i;

  wb_master wb_master_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat));

  irq_flags irq_flags_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .tx_bus_error_i(ev[0]),
    .rx_bus_error_i(ev[1]), .empty_watermark_i(ev[2]),
    .full_watermark_i(ev[3]), .rx_completed_i(ev[4]),
    .rx_activity_i(ev[5]), .tx_completed_i(ev[6]), .tx_aborted_i(ev[7]),
    .rx_no_buffer_i(ev[8]), .rx_fifo_overflow_i(ev[9]),
    .buffer_inc_i(ev[10]), .irq_o(irq), .status_irq_o(sirq));

  task automatic final_report();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    logic to;
    wb_master_inst.xfer(w, a, d, q, to);
    if (to) begin
      errors++;
      final_report();
    end
  endtask

  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
  endtask

  task automatic alias_check();
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_0000);
    bus(1'b1, 8'h08, 32'h0000_63ef);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_60af);
    bus(1'b1, 8'h04, 32'h0000_2001);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_40ae);
    // Pending bit ignores the toggle, it follows the counter
    bus(1'b1, 8'h0c, 32'h0000_40ef);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_0001);
    bus(1'b1, 8'h04, 32'h0000_60af);
  endtask

  task automatic event_check();
    for (int i = 0; i < 10; i++) begin
      if (i == 2 || i == 3) continue;
      pulse(i);
      bus(1'b0, 8'h00, 32'h0);
      chk(q, 32'h1 << pos[i]);
      bus(1'b1, 8'h04, 32'h1 << pos[i]);
    end
  endtask

  task automatic counter_check();
    pulse(10);
    bus(1'b1, 8'h04, 32'h0000_0040);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_0040);
    bus(1'b1, 8'h14, 32'h0000_0001);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_0000);
  endtask

  task automatic irq_check();
    bus(1'b1, 8'h10, 32'h0000_0080);
    bus(1'b1, 8'h1c, 32'h0000_0001);
    pulse(6);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    pulse(4);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, sirq}, 32'h1);
    bus(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0000_0001);
    bus(1'b1, 8'h04, 32'h0000_0080);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, sirq}, 32'h0);
  endtask

  // Watermarks stay sticky, so this runs last
  task automatic wmark_check();
    bus(1'b1, 8'h04, 32'h0000_0008);
    pulse(2);
    pulse(3);
    bus(1'b1, 8'h04, 32'h0000_0300);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_0300);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    alias_check();
    event_check();
    counter_check();
    irq_check();
    wmark_check();
    final_report();
  end
endmodule
